// file: hw/bsa_pkg.sv
// Purpose: Shared constants and types for the board select, acknowledge and interrupt block
// Assumes: 20 MHz system clock, 32-bit processor address bus
// Notes: Counts are in system clock cycles
package bsa_pkg;

	localparam int CLK_HZ = 20000000;

	// Address regions: a hit is (addr & mask) == base
	localparam logic [31:0] DRAM_BASE = 32'h0000_0000;
	localparam logic [31:0] DRAM_MASK = 32'hfe00_0000;
	localparam logic [31:0] FLASH_BASE = 32'hffe0_0000;
	localparam logic [31:0] FLASH_MASK = 32'hfffc_0000;
	localparam logic [31:0] PERIPH_BASE = 32'h3000_0000;
	localparam logic [31:0] PERIPH_MASK = 32'hfff0_0000;
	localparam logic [31:0] ISA_BASE = 32'h4000_0000;
	localparam logic [31:0] ISA_MASK = 32'hfff0_0000;

	// Reset vector fetch size in bytes
	localparam int RESET_VEC_BYTES = 8;

	// Beat timing
	localparam logic [3:0] FLASH_WAIT = 4'h3;
	localparam logic [3:0] DRAM_FIRST_CLK = 4'h3;
	localparam logic [3:0] DRAM_NEXT_CLK = 4'h2;
	localparam logic [3:0] AVEC_CLK = 4'h2;
	localparam logic [1:0] BURST_LAST_BEAT = 2'h3;
	// Counter loads: acknowledge shows when the counter reaches zero
	localparam logic [3:0] FLASH_LOAD = FLASH_WAIT;
	localparam logic [3:0] DRAM_FIRST_LOAD = DRAM_FIRST_CLK - 4'h2;
	localparam logic [3:0] DRAM_NEXT_LOAD = DRAM_NEXT_CLK - 4'h1;
	localparam logic [3:0] AVEC_LOAD = AVEC_CLK - 4'h2;

	// Bus monitor
	localparam int BUS_TMO_CLK = 1024;
	localparam logic [10:0] BUS_TMO_LAST = 11'(BUS_TMO_CLK - 1);

	// Serial/timer peripheral
	localparam logic [7:0] PERIPH_VEC_FIRST = 8'hf0;
	localparam logic [7:0] PERIPH_VEC_LAST = 8'hff;
	localparam int PERIPH_VEC_COUNT = 16;
	localparam int PERIPH_CLK_DIV = 4;
	localparam logic [1:0] PERIPH_DIV_MSB_HALF = 2'h2;
	localparam int TIMER_CLK_HZ = 2457600;
	localparam logic [1:0] BAUD_TIMER_D = 2'h3;

	// Parallel port pin function: zero selects general purpose I/O
	localparam logic [7:0] PAR_PORT_FUNC = 8'h00;

	typedef struct packed {
		logic [2:0] level;
		logic [1:0] prio;
		logic autovec;
	} bsa_irq_cfg_t;

	localparam bsa_irq_cfg_t PERIPH_IRQ_CFG = '{level: 3'h4, prio: 2'h2, autovec: 1'b0};
	localparam bsa_irq_cfg_t UART1_IRQ_CFG = '{level: 3'h3, prio: 2'h2, autovec: 1'b1};
	localparam bsa_irq_cfg_t UART2_IRQ_CFG = '{level: 3'h3, prio: 2'h1, autovec: 1'b1};
	localparam bsa_irq_cfg_t I2C_IRQ_CFG = '{level: 3'h3, prio: 2'h0, autovec: 1'b1};

	typedef struct packed {
		logic flash;
		logic dram;
		logic periph;
		logic periph_in_a;
		logic isa;
		logic avec;
	} bsa_sel_t;

	typedef struct packed {
		bsa_irq_cfg_t periph;
		bsa_irq_cfg_t uart1;
		bsa_irq_cfg_t uart2;
		bsa_irq_cfg_t i2c;
	} bsa_irq_map_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BEAT = 3'b010,
		ST_ERR = 3'b100
	} bsa_state_t;

endpackage

// file: hw/bsa_sync.sv
// Purpose: Two flip-flop synchroniser for a vector of pin inputs
// Assumes: Each bit is an independent level
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns

module bsa_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} bsa_sync_st_t;

	bsa_sync_st_t st_r;
	bsa_sync_st_t st_nxt;

	always_comb begin
		st_nxt.s1 = d_i;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r <= '{s1: RST_VAL, s2: RST_VAL};
		end else if (clk_en_i) begin
			st_r <= st_nxt;
		end
	end

	assign q_o = st_r.s2;

endmodule

// file: hw/bsa_board_ctrl.sv
// Purpose: Address decode, boot alias, acknowledge generation and interrupt routing
// Assumes: Processor bus signals are on clk_i; pins from other boards are not
// Notes: The acknowledge pin is open drain; output enable is low while driving
`timescale 1ns/1ns

// Overview of operation
// (R1) Reset vectors fetched from first eight bytes
// (R2) Flash select answers everywhere until mask written
// (R3) After mask write: flash high, DRAM at zero
// (R4) Cycle opens on start, held until acknowledge
// (R5) Flash and DRAM acknowledged internally after waits
// (R6) Expansion boards only pull acknowledge low
// (R7) Flash acknowledged after three wait states
// (R8) DRAM bursts use 3,2,2,2 clock beats
// (R9) Flash select enables both byte lanes together
// (R10) Peripheral select decoded at 30000000
// (R11) Acknowledge select asserted during peripheral acknowledge
// (R12) Peripheral supplies vectors F0 through FF
// (R13) Eight ISA requests feed I0-I7, forwarded
// (R14) Peripheral requests at level 4, priority 2
// (R15) ISA space decoded at 40000000, 8/16-bit
// (R16) Peripheral clock is system clock over four
// (R17) UART channels level 3, priorities 2 and 1
// (R18) I2C module level 3, priority 0, autovector
// (R19) Parallel port pins all general purpose
// (R20) No acknowledge in 1024 clocks: transfer error
// (R21) ISA space reached through chip select 3
// (R22) One select at most; unmapped gets no acknowledge
module bsa_board_ctrl (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic [31:0] addr_i,
	input wire logic rnw_i,
	input wire logic transfer_start_n_i,
	input wire logic burst_i,
	input wire logic periph_in_a_cycle_i,
	input wire logic [2:0] periph_in_a_level_i,
	input wire logic select0_mask_wr_i,
	input wire logic transfer_ack_n_i,
	output logic transfer_ack_n_o,
	output logic transfer_ack_oe_n_o,
	output logic transfer_err_o,
	output logic autovec_o,
	output logic boot_flash_select_n_o,
	output logic flash_hi_en_n_o,
	output logic flash_lo_en_n_o,
	output logic dram_select_n_o,
	output logic periph_select_n_o,
	output logic periph_in_a_select_n_o,
	output logic periph_in_a_n_o,
	output logic isa_space_select_n_o,
	output logic periph_rnw_o,
	input wire logic [7:0] isa_irq_i,
	output logic [7:0] periph_irq_in_o,
	input wire logic periph_int_n_i,
	output logic periph_irq_line_n_o,
	output logic periph_clk_o,
	output logic [1:0] baud_timer_o,
	output logic [7:0] periph_vec_first_o,
	output logic [7:0] periph_vec_last_o,
	output bsa_pkg::bsa_irq_map_t irq_map_o,
	output logic [7:0] par_port_func_o,
	output logic boot_alias_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Types and state

	typedef struct packed {
		bsa_pkg::bsa_state_t state;
		bsa_pkg::bsa_sel_t sel;
		logic rnw;
		logic [3:0] cnt;
		logic [1:0] beat;
		logic [10:0] tmo;
		logic boot_alias;
		logic [1:0] div;
		logic [1:0] own_ack;
	} bsa_ctrl_st_t;

	bsa_ctrl_st_t st_r;
	bsa_ctrl_st_t st_nxt;

	logic ext_ack_n_s;
	logic [7:0] isa_irq_s;
	logic periph_int_n_s;
	logic internal_sel;
	logic ack_int;
	logic ext_term;
	logic beat_done;
	logic more_beats;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	bsa_sync #(
		.W(10),
		.RST_VAL(10'h201)
	) u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en_i),
		.d_i({transfer_ack_n_i, isa_irq_i, periph_int_n_i}),
		.q_o({ext_ack_n_s, isa_irq_s, periph_int_n_s})
	);

	////////////////////////////////////////////////////////////////////////////////
	// Decode

	function automatic logic region_hit(input logic [31:0] a, input logic [31:0] base,
			input logic [31:0] mask);
		region_hit = (a & mask) == base;
	endfunction

	// Priority chain keeps at most one select active
	function automatic bsa_pkg::bsa_sel_t decode(input logic [31:0] a, input logic alias_on,
			input logic periph_in_a, input logic [2:0] lvl);
		decode = '0;
		if (periph_in_a) begin
			if (lvl == bsa_pkg::PERIPH_IRQ_CFG.level) begin
				decode.periph_in_a = 1'b1; // R11 R14
			end else begin
				decode.avec = 1'b1; // R17 R18
			end
		end else if (alias_on) begin
			decode.flash = 1'b1; // R2 R1
		end else if (region_hit(a, bsa_pkg::FLASH_BASE, bsa_pkg::FLASH_MASK)) begin
			decode.flash = 1'b1; // R3
		end else if (region_hit(a, bsa_pkg::DRAM_BASE, bsa_pkg::DRAM_MASK)) begin
			decode.dram = 1'b1; // R3
		end else if (region_hit(a, bsa_pkg::PERIPH_BASE, bsa_pkg::PERIPH_MASK)) begin
			decode.periph = 1'b1; // R10
		end else if (region_hit(a, bsa_pkg::ISA_BASE, bsa_pkg::ISA_MASK)) begin
			decode.isa = 1'b1; // R15 R21
		end
	endfunction

	function automatic logic [3:0] first_load(input bsa_pkg::bsa_sel_t s);
		if (s.flash) begin
			first_load = bsa_pkg::FLASH_LOAD; // R7
		end else if (s.dram) begin
			first_load = bsa_pkg::DRAM_FIRST_LOAD; // R8
		end else begin
			first_load = bsa_pkg::AVEC_LOAD;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Termination

	// Flash, DRAM and autovector cycles end on the counter; the rest wait for the pin
	assign internal_sel = st_r.sel.flash | st_r.sel.dram | st_r.sel.avec; // R5
	assign ack_int = (st_r.state == bsa_pkg::ST_BEAT) && internal_sel && (st_r.cnt == 4'h0);
	// Our own acknowledge comes back through the synchroniser two cycles later; ignore that echo
	assign ext_term = (st_r.state == bsa_pkg::ST_BEAT) && !internal_sel && !ext_ack_n_s &&
		!st_r.own_ack[1]; // R6 R22 R4
	assign beat_done = ack_int | ext_term;
	assign more_beats = st_r.sel.dram && burst_i && (st_r.beat != bsa_pkg::BURST_LAST_BEAT);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_nxt = st_r;
		st_nxt.div = st_r.div + 2'h1; // R16
		st_nxt.own_ack = {st_r.own_ack[0], ack_int};
		if (select0_mask_wr_i) begin
			st_nxt.boot_alias = 1'b0; // R2
		end
		case (st_r.state)
			bsa_pkg::ST_IDLE: begin
				if (!transfer_start_n_i) begin
					st_nxt.sel = decode(addr_i, st_r.boot_alias, periph_in_a_cycle_i, periph_in_a_level_i);
					st_nxt.rnw = rnw_i;
					st_nxt.cnt = first_load(st_nxt.sel);
					st_nxt.beat = 2'h0;
					st_nxt.tmo = 11'h000;
					st_nxt.state = bsa_pkg::ST_BEAT; // R4
				end
			end
			bsa_pkg::ST_BEAT: begin
				if (beat_done) begin
					st_nxt.tmo = 11'h000;
					if (more_beats) begin
						st_nxt.beat = st_r.beat + 2'h1;
						st_nxt.cnt = bsa_pkg::DRAM_NEXT_LOAD; // R8
					end else begin
						st_nxt.sel = '0;
						st_nxt.state = bsa_pkg::ST_IDLE;
					end
				end else if (st_r.tmo == bsa_pkg::BUS_TMO_LAST) begin
					st_nxt.sel = '0;
					st_nxt.state = bsa_pkg::ST_ERR; // R20 R22
				end else begin
					st_nxt.tmo = st_r.tmo + 11'h001;
					if (st_r.cnt != 4'h0) begin
						st_nxt.cnt = st_r.cnt - 4'h1; // R5
					end
				end
			end
			bsa_pkg::ST_ERR: begin
				st_nxt.state = bsa_pkg::ST_IDLE;
			end
			default: begin
				st_nxt.state = bsa_pkg::ST_IDLE;
				st_nxt.sel = '0;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r.state <= bsa_pkg::ST_IDLE;
			st_r.sel <= '0;
			st_r.rnw <= 1'b1;
			st_r.cnt <= 4'h0;
			st_r.beat <= 2'h0;
			st_r.tmo <= 11'h000;
			st_r.boot_alias <= 1'b1; // R2
			st_r.div <= 2'h0;
			st_r.own_ack <= 2'h0;
		end else if (clk_en_i) begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus outputs

	// Open drain acknowledge: drive low only, pull-up gives the idle level
	assign transfer_ack_n_o = 1'b0;
	assign transfer_ack_oe_n_o = !ack_int; // R5 R6
	assign transfer_err_o = (st_r.state == bsa_pkg::ST_ERR); // R20
	assign autovec_o = ack_int && st_r.sel.avec; // R17 R18

	assign boot_flash_select_n_o = !st_r.sel.flash;
	assign flash_hi_en_n_o = !st_r.sel.flash; // R9
	assign flash_lo_en_n_o = !st_r.sel.flash; // R9
	assign dram_select_n_o = !st_r.sel.dram;
	assign periph_select_n_o = !st_r.sel.periph; // R10
	assign periph_in_a_select_n_o = !st_r.sel.periph_in_a; // R11
	assign periph_in_a_n_o = !st_r.sel.periph_in_a; // R11
	assign isa_space_select_n_o = !st_r.sel.isa; // R15 R21
	assign periph_rnw_o = st_r.rnw;
	assign boot_alias_o = st_r.boot_alias;

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt routing and peripheral setup

	assign periph_irq_in_o = isa_irq_s; // R13
	assign periph_irq_line_n_o = periph_int_n_s; // R13
	assign periph_clk_o = st_r.div[1]; // R16
	assign baud_timer_o = bsa_pkg::BAUD_TIMER_D; // R16
	assign periph_vec_first_o = bsa_pkg::PERIPH_VEC_FIRST; // R12
	assign periph_vec_last_o = bsa_pkg::PERIPH_VEC_LAST; // R12
	assign irq_map_o.periph = bsa_pkg::PERIPH_IRQ_CFG; // R14
	assign irq_map_o.uart1 = bsa_pkg::UART1_IRQ_CFG; // R17
	assign irq_map_o.uart2 = bsa_pkg::UART2_IRQ_CFG; // R17
	assign irq_map_o.i2c = bsa_pkg::I2C_IRQ_CFG; // R18
	assign par_port_func_o = bsa_pkg::PAR_PORT_FUNC; // R19

endmodule

// file: verification/bsa_ctrl_props.sv
// Purpose: Port assertions for the board control block
// Assumes: One clock domain, clk_en_i held high
// Notes: Bound into every instance of the block
`timescale 1ns/1ns
module bsa_ctrl_props (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic select0_mask_wr_i,
	input wire logic transfer_ack_oe_n_o,
	input wire logic boot_flash_select_n_o,
	input wire logic flash_hi_en_n_o,
	input wire logic flash_lo_en_n_o,
	input wire logic dram_select_n_o,
	input wire logic periph_select_n_o,
	input wire logic periph_in_a_select_n_o,
	input wire logic periph_in_a_n_o,
	input wire logic isa_space_select_n_o,
	input wire logic [7:0] isa_irq_i,
	input wire logic [7:0] periph_irq_in_o,
	input wire logic periph_clk_o,
	input wire logic boot_alias_o
);
	logic [1:0] age_r;
	// Age since reset keeps the synchroniser check clear of reset values
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) age_r <= 2'h0;
		else if (age_r != 2'h3) age_r <= age_r + 2'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////
	a_flash_wait: assert property (
		$fell(boot_flash_select_n_o) |-> transfer_ack_oe_n_o[*3] ##1 !transfer_ack_oe_n_o)
		else $error("flash acknowledge not after three waits");
	a_dram_first: assert property (
		$fell(dram_select_n_o) |-> ##1 !transfer_ack_oe_n_o)
		else $error("dram first beat not in three clocks");
	a_dram_next: assert property (
		(!transfer_ack_oe_n_o && !dram_select_n_o) ##1 !dram_select_n_o
		|-> transfer_ack_oe_n_o ##1 !transfer_ack_oe_n_o)
		else $error("dram later beat not two clocks");
	a_ack_pulse: assert property (
		!transfer_ack_oe_n_o |=> transfer_ack_oe_n_o)
		else $error("acknowledge longer than one cycle");
	a_one_select: assert property (
		$onehot0(~{boot_flash_select_n_o, dram_select_n_o, periph_select_n_o,
		periph_in_a_select_n_o, isa_space_select_n_o}))
		else $error("more than one select");
	a_flash_lanes: assert property (
		flash_hi_en_n_o == boot_flash_select_n_o && flash_lo_en_n_o == boot_flash_select_n_o)
		else $error("flash byte lanes not with select");
	a_periph_in_a_pair: assert property (
		periph_in_a_n_o == periph_in_a_select_n_o)
		else $error("peripheral acknowledge input not with select");
	a_alias_clear: assert property (
		select0_mask_wr_i |=> !boot_alias_o)
		else $error("boot alias not cleared");
	a_alias_hold: assert property (
		boot_alias_o && !select0_mask_wr_i |=> boot_alias_o)
		else $error("boot alias lost");
	a_irq_route: assert property (
		age_r == 2'h3 |-> periph_irq_in_o == $past(isa_irq_i, 2))
		else $error("request routing wrong");
	a_periph_clk: assert property (
		$rose(periph_clk_o) |-> periph_clk_o [*2] ##1 !periph_clk_o [*2] ##1 periph_clk_o)
		else $error("peripheral clock not divide by four");
endmodule
bind bsa_board_ctrl bsa_ctrl_props u_props (.clk_i, .sys_rst_i, .select0_mask_wr_i,
	.transfer_ack_oe_n_o, .boot_flash_select_n_o, .flash_hi_en_n_o, .flash_lo_en_n_o,
	.dram_select_n_o, .periph_select_n_o, .periph_in_a_select_n_o, .periph_in_a_n_o,
	.isa_space_select_n_o, .isa_irq_i, .periph_irq_in_o, .periph_clk_o, .boot_alias_o);

// file: verification/bsa_far_end.sv
// Purpose: Expansion board or peripheral ending cycles on the wired acknowledge
// Assumes: Select input active low
// Notes: Pulls the line for one cycle after dly_i, never drives it high
`timescale 1ns/1ns
module bsa_far_end (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic sel_n_i,
	input wire logic [3:0] dly_i,
	output logic pull_o
);
	logic [3:0] cnt_r;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_r <= 4'h0;
			pull_o <= 1'b0;
		end else if (sel_n_i) begin
			cnt_r <= 4'h0;
			pull_o <= 1'b0;
		end else begin
			if (cnt_r != 4'hf) cnt_r <= cnt_r + 4'h1;
			pull_o <= (cnt_r == dly_i) && !pull_o;
		end
	end
endmodule

// file: verification/bsa_board_ctrl_bench.sv
// Purpose: Self-checking bench for the board control block
// Assumes: Inputs change at the falling edge
// Notes: Wired acknowledge has a pull-up
`timescale 1ns/1ns
module bsa_board_ctrl_bench;
	logic clk_i, sys_rst_i, rnw_i, transfer_start_n_i, burst_i, periph_in_a_cycle_i;
	logic select0_mask_wr_i, periph_int_n_i, pull, av1;
	logic [31:0] addr_i;
	logic [2:0] periph_in_a_level_i;
	logic [3:0] dly;
	logic [4:0] sel1;
	logic [7:0] isa_irq_i, periph_irq_in_o, periph_vec_first_o, periph_vec_last_o;
	logic [7:0] par_port_func_o;
	logic transfer_ack_oe_n_o, transfer_err_o, autovec_o, boot_flash_select_n_o;
	logic dram_select_n_o, periph_select_n_o, periph_in_a_select_n_o, isa_space_select_n_o;
	logic periph_irq_line_n_o, boot_alias_o, periph_rnw_o, transfer_ack_n_o;
	logic [1:0] baud_timer_o;
	bsa_pkg::bsa_irq_map_t irq_map_o;
	int bad_count, comparisons, nack, ack_k, end_k, err_k;
	wire logic transfer_ack_n_i = !(!transfer_ack_oe_n_o || pull);
	wire logic [4:0] sel = ~{boot_flash_select_n_o, dram_select_n_o, periph_select_n_o,
		periph_in_a_select_n_o, isa_space_select_n_o};
	bsa_board_ctrl dut (.clk_i, .sys_rst_i, .clk_en_i(1'b1), .addr_i, .rnw_i,
		.transfer_start_n_i, .burst_i, .periph_in_a_cycle_i, .periph_in_a_level_i, .select0_mask_wr_i,
		.transfer_ack_n_i, .transfer_ack_n_o, .transfer_ack_oe_n_o, .transfer_err_o,
		.autovec_o, .boot_flash_select_n_o, .flash_hi_en_n_o(), .flash_lo_en_n_o(),
		.dram_select_n_o, .periph_select_n_o, .periph_in_a_select_n_o, .periph_in_a_n_o(),
		.isa_space_select_n_o, .periph_rnw_o, .isa_irq_i, .periph_irq_in_o,
		.periph_int_n_i, .periph_irq_line_n_o, .periph_clk_o(), .baud_timer_o,
		.periph_vec_first_o, .periph_vec_last_o, .irq_map_o, .par_port_func_o, .boot_alias_o);
	bsa_far_end far (.clk_i, .sys_rst_i, .dly_i(dly), .pull_o(pull),
		.sel_n_i(periph_select_n_o & isa_space_select_n_o & periph_in_a_select_n_o));
	////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic close_out();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// One bus cycle: start pulse, then watch until selects drop or error
	task automatic run(input logic [31:0] a, input logic ia, input logic [2:0] lv,
		input logic bu);
		@(negedge clk_i);
		addr_i = a;
		periph_in_a_cycle_i = ia;
		periph_in_a_level_i = lv;
		burst_i = bu;
		rnw_i = ~rnw_i;
		transfer_start_n_i = 1'b0;
		nack = 0;
		ack_k = 0;
		end_k = 0;
		err_k = 0;
		for (int k = 1; k < 1100 && end_k == 0; k++) begin
			@(negedge clk_i);
			transfer_start_n_i = 1'b1;
			if (k == 1) begin
				sel1 = sel;
				av1 = autovec_o;
				chk(periph_rnw_o, rnw_i);
			end
			if (transfer_ack_oe_n_o === 1'b0) nack++;
			if (transfer_ack_oe_n_o === 1'b0 && ack_k == 0) ack_k = k;
			if (transfer_err_o === 1'b1) err_k = k;
			// Unmapped cycles show no select, so only an acknowledge or the transfer error ends them early
			if ((k > 1 && sel === 5'h0 && (sel1 !== 5'h0 || ack_k != 0)) ||
				transfer_err_o === 1'b1) end_k = k;
		end
		burst_i = 1'b0;
		if (end_k == 0) begin
			bad_count++;
			$display("MISMATCH at %0t: bus cycle never ended", $time);
		end
	endtask
	////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		#(5000 * 50);
		bad_count++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		close_out();
	end
	initial begin
		{rnw_i, burst_i, periph_in_a_cycle_i, select0_mask_wr_i, dly} = '0;
		{transfer_start_n_i, periph_int_n_i, sys_rst_i} = 3'h7;
		addr_i = 32'h0;
		periph_in_a_level_i = 3'h0;
		isa_irq_i = 8'h00;
		repeat (12) @(posedge clk_i);
		@(negedge clk_i);
		sys_rst_i = 1'b0;
		chk(boot_alias_o, 1'b1);
		run(32'h0000_0000, 1'b0, 3'h0, 1'b0);
		chk(sel1, 5'h10);
		chk(ack_k, 4);
		chk(end_k, 5);
		run(32'h3000_0000, 1'b0, 3'h0, 1'b0);
		chk(sel1, 5'h10);
		$display("boot alias test done");
		select0_mask_wr_i = 1'b1;
		@(negedge clk_i);
		select0_mask_wr_i = 1'b0;
		chk(boot_alias_o, 1'b0);
		run(32'h0000_0000, 1'b0, 3'h0, 1'b1);
		chk(sel1, 5'h08);
		chk(ack_k, 32'd2);
		chk(nack, 32'd4);
		chk(end_k, 32'd9);
		run(32'hffe0_0000, 1'b0, 3'h0, 1'b0);
		chk(sel1, 5'h10);
		chk(ack_k, 32'd4);
		run(32'h3000_0000, 1'b0, 3'h0, 1'b0);
		chk(sel1, 5'h04);
		chk(nack, 32'd0);
		chk(end_k, 32'd5);
		dly = 4'h5;
		run(32'h4000_0000, 1'b0, 3'h0, 1'b0);
		chk(sel1, 5'h01);
		chk(nack, 32'd0);
		chk(end_k, 32'd10);
		$display("decode test done");
		run(32'h5000_0000, 1'b0, 3'h0, 1'b0);
		chk(sel1, 5'h00);
		chk(nack, 32'd0);
		chk(err_k, 32'd1025);
		$display("timeout test done");
		dly = 4'h0;
		run(32'hffff_fff0, 1'b1, 3'h4, 1'b0);
		chk(sel1, 5'h02);
		chk(av1, 1'b0);
		chk(end_k, 32'd5);
		run(32'hffff_fff0, 1'b1, 3'h3, 1'b0);
		chk(sel1, 5'h00);
		chk(av1, 1'b1);
		chk(ack_k, 32'd1);
		$display("acknowledge test done");
		isa_irq_i = 8'ha5;
		periph_int_n_i = 1'b0;
		repeat (3) @(negedge clk_i);
		chk(periph_irq_in_o, 8'ha5);
		chk(periph_irq_line_n_o, 1'b0);
		chk({periph_vec_first_o, periph_vec_last_o}, 16'hf0ff);
		chk(baud_timer_o, 2'h3);
		chk(par_port_func_o, 8'h00);
		chk(transfer_ack_n_o, 1'b0);
		chk(irq_map_o, {6'h24, 6'h1d, 6'h1b, 6'h19});
		$display("interrupt and constant test done");
		close_out();
	end
endmodule
